/* File: logic/lmac_pkg.sv */
// Constants for the long-mode activation control block
package lmac_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PAGING   = 8'h00;
  localparam logic [7:0] OFS_ADDR_EXT = 8'h04;
  localparam logic [7:0] OFS_LM_EN    = 8'h08;
  localparam logic [7:0] OFS_CODE     = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_PMB_LO   = 8'h14;
  localparam logic [7:0] OFS_PMB_HI   = 8'h18;
  localparam logic [7:0] OFS_TBL_BASE = 8'h20;
  localparam logic [7:0] OFS_TBL_LAST = 8'h2C;
  localparam logic [7:0] OFS_INT_STAT = 8'h30;
  localparam logic [7:0] OFS_INT_CLR  = 8'h34;
  localparam logic [7:0] OFS_INT_EN   = 8'h38;
  localparam logic [7:0] OFS_FAULT    = 8'h3C;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_BIT       = 0;
  localparam int ST_ACTIVE_BIT  = 0;
  localparam int ST_LEGACY_BIT  = 1;
  localparam int ST_GATE64_BIT  = 2;
  localparam int EV_FAULT_BIT   = 0;
  localparam int EV_ACT_BIT     = 1;
  localparam int EV_DEACT_BIT   = 2;
  localparam int EV_W           = 3;
  localparam int CAUSE_W        = 4;
  localparam int ERRCODE_LSB    = 16;
  // ----------------------------------------------------------------
  // Reset and fixed values
  // ----------------------------------------------------------------
  localparam logic [15:0] FAULT_CODE  = 16'h0000;
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED    = 32'h0000_0000;
endpackage

/* File: logic/lmac_top.sv */
// Long-mode activation control with APB register access
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/100ps
module lmac_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Mode outputs
  output logic             long_mode_active,
  output logic             gate64_fetch,
  output logic             legacy32_mode,
  output logic             general_protection_fault,
  output logic             irq
);
  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_word;
  logic        mapped;
  logic        acc;
  logic        wr;

  // Write or read completes on the second access cycle
  assign acc = psel & penable & pready_q;
  assign wr  = acc & pwrite;

  // One wait state, answer registered
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= lmac_pkg::RST_WORD;
    end else begin
      pready_q  <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~mapped;
      if (psel & penable & ~pready_q) begin
        prdata_q <= pwrite ? lmac_pkg::RST_WORD : rd_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control bits and consistency checks
  // ----------------------------------------------------------------
  logic               page_q;
  logic               ext_q;
  logic               en_q;
  logic               csl_q;
  logic               act_q;
  logic               act_d;
  logic               d_bit;
  logic               wr_page;
  logic               wr_ext;
  logic               wr_en;
  logic               f_en;
  logic               f_no_ext;
  logic               f_csl;
  logic               f_ext_clr;
  logic               fault;
  logic [lmac_pkg::CAUSE_W-1:0] cause_q;

  assign d_bit   = pwdata[lmac_pkg::CTRL_BIT];
  assign wr_page = wr & (paddr == lmac_pkg::OFS_PAGING);
  assign wr_ext  = wr & (paddr == lmac_pkg::OFS_ADDR_EXT);
  assign wr_en   = wr & (paddr == lmac_pkg::OFS_LM_EN);

  // Checks judged on every write to a watched bit
  assign f_en      = wr_en & (d_bit != en_q) & page_q;
  assign f_no_ext  = wr_page & ~page_q & d_bit & en_q & ~ext_q;
  assign f_csl     = wr_page & ~page_q & d_bit & en_q & csl_q;
  assign f_ext_clr = wr_ext & ext_q & ~d_bit & act_q;
  assign fault     = f_en | f_no_ext | f_csl | f_ext_clr;

  // Active state follows paging transitions
  always_comb begin
    act_d = act_q;
    if (wr_page & ~fault) begin
      if (~d_bit) begin
        act_d = 1'b0;
      end else if (~page_q & en_q) begin
        act_d = 1'b1;
      end
    end
  end

  // Control bits update only when no check fails
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      page_q <= 1'b0;
      ext_q  <= 1'b0;
      en_q   <= 1'b0;
      csl_q  <= 1'b0;
      act_q  <= 1'b0;
    end else begin
      act_q <= act_d;
      if (wr_page & ~fault) begin
        page_q <= d_bit;
      end
      if (wr_ext & ~fault) begin
        ext_q <= d_bit;
      end
      if (wr_en & ~fault) begin
        en_q <= d_bit;
      end
      if (wr & (paddr == lmac_pkg::OFS_CODE)) begin
        csl_q <= d_bit;
      end
    end
  end

  // Fault cause of the last failed write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cause_q <= '0;
    end else if (fault) begin
      cause_q <= {f_ext_clr, f_csl, f_no_ext, f_en};
    end
  end

  // ----------------------------------------------------------------
  // Page-map base and descriptor-table registers
  // ----------------------------------------------------------------
  logic [31:0] pmb_lo_q;
  logic [31:0] pmb_hi_q;
  logic [31:0] tbl_q [4];
  logic        tbl_hit;

  assign tbl_hit = (paddr >= lmac_pkg::OFS_TBL_BASE) & (paddr <= lmac_pkg::OFS_TBL_LAST);

  // Upper half held at zero until long mode is active
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pmb_lo_q <= lmac_pkg::RST_WORD;
      pmb_hi_q <= lmac_pkg::RST_WORD;
    end else if (wr & (paddr == lmac_pkg::OFS_PMB_LO)) begin
      pmb_lo_q <= pwdata;
      if (~act_q) begin
        pmb_hi_q <= lmac_pkg::RST_WORD;
      end
    end else if (wr & (paddr == lmac_pkg::OFS_PMB_HI) & act_q) begin
      pmb_hi_q <= pwdata;
    end
  end

  // Table registers change only by software writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) begin
        tbl_q[i] <= lmac_pkg::RST_WORD;
      end
    end else if (wr & tbl_hit) begin
      tbl_q[paddr[3:2]] <= pwdata;
    end
  end

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  logic [lmac_pkg::EV_W-1:0] ev;
  logic [lmac_pkg::EV_W-1:0] int_stat_q;
  logic [lmac_pkg::EV_W-1:0] int_stat_d;
  logic [lmac_pkg::EV_W-1:0] int_en_q;
  logic [lmac_pkg::EV_W-1:0] clr;
  logic                      irq_q;
  logic                      fault_q;

  assign ev[lmac_pkg::EV_FAULT_BIT] = fault;
  assign ev[lmac_pkg::EV_ACT_BIT]   = act_d & ~act_q;
  assign ev[lmac_pkg::EV_DEACT_BIT] = ~act_d & act_q;
  assign clr = (wr & (paddr == lmac_pkg::OFS_INT_CLR)) ? pwdata[lmac_pkg::EV_W-1:0] : '0;
  // Set wins over a clear in the same cycle
  assign int_stat_d = (int_stat_q & ~clr) | ev;

  // Sticky status, enable and level interrupt
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      int_stat_q <= '0;
      int_en_q   <= '0;
      irq_q      <= 1'b0;
      fault_q    <= 1'b0;
    end else begin
      int_stat_q <= int_stat_d;
      fault_q    <= fault;
      if (wr & (paddr == lmac_pkg::OFS_INT_EN)) begin
        int_en_q <= pwdata[lmac_pkg::EV_W-1:0];
      end
      irq_q <= |(int_stat_d & ((wr & (paddr == lmac_pkg::OFS_INT_EN)) ?
               pwdata[lmac_pkg::EV_W-1:0] : int_en_q));
    end
  end

  // ----------------------------------------------------------------
  // Mode outputs
  // ----------------------------------------------------------------
  logic gate64_q;
  logic legacy_q;

  // Gate format and legacy behaviour track the active state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gate64_q <= 1'b0;
      legacy_q <= 1'b1;
    end else begin
      gate64_q <= act_d;
      legacy_q <= ~act_d;
    end
  end

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = lmac_pkg::UNMAPPED;
    mapped  = 1'b1;
    if (tbl_hit) begin
      rd_word = tbl_q[paddr[3:2]];
    end else begin
      case (paddr)
        lmac_pkg::OFS_PAGING:   rd_word[lmac_pkg::CTRL_BIT] = page_q;
        lmac_pkg::OFS_ADDR_EXT: rd_word[lmac_pkg::CTRL_BIT] = ext_q;
        lmac_pkg::OFS_LM_EN:    rd_word[lmac_pkg::CTRL_BIT] = en_q;
        lmac_pkg::OFS_CODE:     rd_word[lmac_pkg::CTRL_BIT] = csl_q;
        lmac_pkg::OFS_STATUS: begin
          rd_word[lmac_pkg::ST_ACTIVE_BIT] = act_q;
          rd_word[lmac_pkg::ST_LEGACY_BIT] = legacy_q;
          rd_word[lmac_pkg::ST_GATE64_BIT] = gate64_q;
        end
        lmac_pkg::OFS_PMB_LO:   rd_word = pmb_lo_q;
        lmac_pkg::OFS_PMB_HI:   rd_word = pmb_hi_q;
        lmac_pkg::OFS_INT_STAT: rd_word[lmac_pkg::EV_W-1:0] = int_stat_q;
        lmac_pkg::OFS_INT_CLR:  rd_word = lmac_pkg::UNMAPPED;
        lmac_pkg::OFS_INT_EN:   rd_word[lmac_pkg::EV_W-1:0] = int_en_q;
        lmac_pkg::OFS_FAULT: begin
          rd_word[lmac_pkg::CAUSE_W-1:0] = cause_q;
          rd_word[31:lmac_pkg::ERRCODE_LSB] = lmac_pkg::FAULT_CODE;
        end
        default:                mapped = 1'b0;
      endcase
    end
  end

  // Outputs straight from flops
  assign prdata                   = prdata_q;
  assign pready                   = pready_q;
  assign pslverr                  = pslverr_q;
  assign long_mode_active         = act_q;
  assign gate64_fetch             = gate64_q;
  assign legacy32_mode            = legacy_q;
  assign general_protection_fault = fault_q;
  assign irq                      = irq_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_act_set: assert property (wr_page && d_bit && !page_q && en_q && ext_q && !csl_q |=> act_q && page_q)
    else $error("active not set on paging enable");
  chk_act_clr: assert property (wr_page && !d_bit |=> !act_q ##1 legacy32_mode)
    else $error("active not cleared on paging disable");
  chk_en_fault: assert property (wr_en && (d_bit != en_q) && page_q |=> fault_q && $stable(en_q))
    else $error("enable change under paging not refused");
  chk_noext_fault: assert property (wr_page && !page_q && d_bit && en_q && !ext_q |=> fault_q && !page_q && !act_q)
    else $error("paging without extension not refused");
  chk_code_fault: assert property (wr_page && !page_q && d_bit && en_q && csl_q |=> fault_q && !page_q)
    else $error("paging with long code not refused");
  chk_ext_keep: assert property (wr_ext && !d_bit && act_q |=> fault_q && ext_q)
    else $error("extension clear while active not refused");
  chk_pmb_hi: assert property (wr && (paddr == lmac_pkg::OFS_PMB_HI) && !act_q |=> $stable(pmb_hi_q))
    else $error("upper page-map base written before activation");
  chk_tbl_keep: assert property ($rose(act_q) |-> tbl_q[2] == $past(tbl_q[2]) && tbl_q[0] == $past(tbl_q[0]))
    else $error("table register moved on activation");
  chk_gate_fmt: assert property (gate64_fetch == act_q && legacy32_mode == !act_q)
    else $error("gate format out of step with active");
  chk_no_side: assert property (fault |=> $stable(page_q) && $stable(en_q) && $stable(ext_q) && $stable(act_q))
    else $error("failed write changed control state");
  chk_any_fault: assert property (fault |=> fault_q ##1 int_stat_q[lmac_pkg::EV_FAULT_BIT])
    else $error("failed check not reported");
  chk_apb_wait: assert property (psel && penable && !pready_q |=> pready_q ##1 !pready_q)
    else $error("bus answer not after one wait");

  cov_activate: cover property ($rose(act_q));
  cov_deact:    cover property ($fell(act_q));
  cov_fault:    cover property (fault_q && irq_q);
endmodule

/* File: dv/lmac_sw_model.sv */
// Software-side model issuing APB mode-switch sequences
`timescale 1ns/100ps
module lmac_sw_model (
  // Clock
  input  wire logic        clk,
  // APB master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Idle bus at time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // One transfer, request held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d; // Released data no longer shows last value
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
    xfer(1'b0, a, 32'h0000_0000, q, e);
  endtask

  // Entry: paging off, then extension, base, enable, then paging on
  // No interrupt source on this side during the switch
  task automatic enter_long(input logic [31:0] base);
    wr(lmac_pkg::OFS_PAGING, 32'h0000_0000);
    wr(lmac_pkg::OFS_ADDR_EXT, 32'h0000_0001);
    wr(lmac_pkg::OFS_PMB_LO, base);
    wr(lmac_pkg::OFS_LM_EN, 32'h0000_0001);
    wr(lmac_pkg::OFS_PAGING, 32'h0000_0001);
  endtask

  // Exit: compatibility code, paging off, legacy base, disable, paging on
  task automatic leave_long(input logic [31:0] base);
    wr(lmac_pkg::OFS_CODE, 32'h0000_0000);
    wr(lmac_pkg::OFS_PAGING, 32'h0000_0000);
    wr(lmac_pkg::OFS_PMB_LO, base);
    wr(lmac_pkg::OFS_LM_EN, 32'h0000_0000);
    wr(lmac_pkg::OFS_PAGING, 32'h0000_0001);
  endtask
endmodule

/* File: dv/long_mode_activation_control_tb.sv */
// Self-checking testbench for the long-mode activation control block
`timescale 1ns/100ps
module long_mode_activation_control_tb;
  logic        clk = 1'b0;
  logic        arst_n;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        long_mode_active, gate64_fetch, legacy32_mode, general_protection_fault, irq;
  int          fail_count = 0;
  int          comparisons = 0;
  int          fault_cnt = 0;

  // Clock, 25 ns period
  always #12.5 clk = ~clk;

  lmac_top dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .long_mode_active(long_mode_active), .gate64_fetch(gate64_fetch), .legacy32_mode(legacy32_mode),
    .general_protection_fault(general_protection_fault), .irq(irq));

  lmac_sw_model sw (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Count fault pulses
  always @(posedge clk) if (general_protection_fault === 1'b1) fault_cnt++;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    logic        s;
    sw.rd(a, q, s);
    chk(q, e);
    chk({31'h0000_0000, s}, 32'h0000_0000);
  endtask

  // Port levels as {irq, gate64, legacy32, active}
  task automatic ports(input logic [3:0] e);
    chk({28'h000_0000, irq, gate64_fetch, legacy32_mode, long_mode_active}, {28'h000_0000, e});
  endtask

  task automatic t_reset;
    ports(4'b0010);
    rdc(lmac_pkg::OFS_STATUS, 32'h0000_0002);
    rdc(lmac_pkg::OFS_INT_STAT, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_enter;
    sw.wr(lmac_pkg::OFS_INT_EN, 32'h0000_0007);
    sw.wr(lmac_pkg::OFS_TBL_BASE, 32'h1234_5678);
    sw.wr(lmac_pkg::OFS_PMB_HI, 32'h0000_0005);
    rdc(lmac_pkg::OFS_PMB_HI, 32'h0000_0000);
    sw.enter_long(32'h0000_A000);
    rdc(lmac_pkg::OFS_PMB_LO, 32'h0000_A000);
    rdc(lmac_pkg::OFS_PMB_HI, 32'h0000_0000);
    rdc(lmac_pkg::OFS_STATUS, 32'h0000_0005);
    ports(4'b1101);
    rdc(lmac_pkg::OFS_TBL_BASE, 32'h1234_5678);
    sw.wr(lmac_pkg::OFS_TBL_LAST, 32'h0000_C000);
    rdc(lmac_pkg::OFS_TBL_LAST, 32'h0000_C000);
    rdc(lmac_pkg::OFS_INT_STAT, 32'h0000_0002);
    chk(32'(fault_cnt), 32'h0000_0000);
    sw.wr(lmac_pkg::OFS_PMB_HI, 32'h0000_0005);
    rdc(lmac_pkg::OFS_PMB_HI, 32'h0000_0005);
    $display("test enter done");
  endtask

  task automatic t_active_faults;
    sw.wr(lmac_pkg::OFS_INT_CLR, 32'h0000_0007);
    rdc(lmac_pkg::OFS_INT_STAT, 32'h0000_0000);
    ports(4'b0101);
    sw.wr(lmac_pkg::OFS_LM_EN, 32'h0000_0000);
    rdc(lmac_pkg::OFS_FAULT, 32'h0000_0001);
    rdc(lmac_pkg::OFS_LM_EN, 32'h0000_0001);
    rdc(lmac_pkg::OFS_INT_STAT, 32'h0000_0001);
    chk(32'(fault_cnt), 32'h0000_0001);
    sw.wr(lmac_pkg::OFS_ADDR_EXT, 32'h0000_0000);
    rdc(lmac_pkg::OFS_FAULT, 32'h0000_0008);
    rdc(lmac_pkg::OFS_ADDR_EXT, 32'h0000_0001);
    rdc(lmac_pkg::OFS_STATUS, 32'h0000_0005);
    sw.wr(lmac_pkg::OFS_LM_EN, 32'h0000_0001);
    sw.wr(lmac_pkg::OFS_INT_EN, 32'h0000_0000);
    rdc(lmac_pkg::OFS_INT_STAT, 32'h0000_0001);
    ports(4'b0101);
    chk(32'(fault_cnt), 32'h0000_0002);
    sw.wr(lmac_pkg::OFS_INT_CLR, 32'h0000_0007);
    sw.wr(lmac_pkg::OFS_INT_EN, 32'h0000_0007);
    $display("test active faults done");
  endtask

  task automatic t_leave;
    sw.leave_long(32'h0000_3000);
    rdc(lmac_pkg::OFS_STATUS, 32'h0000_0002);
    rdc(lmac_pkg::OFS_INT_STAT, 32'h0000_0004);
    ports(4'b1010);
    chk(32'(fault_cnt), 32'h0000_0002);
    sw.wr(lmac_pkg::OFS_LM_EN, 32'h0000_0001);
    rdc(lmac_pkg::OFS_FAULT, 32'h0000_0001);
    rdc(lmac_pkg::OFS_LM_EN, 32'h0000_0000);
    chk(32'(fault_cnt), 32'h0000_0003);
    sw.wr(lmac_pkg::OFS_PAGING, 32'h0000_0000);
    $display("test leave done");
  endtask

  task automatic t_entry_faults;
    sw.wr(lmac_pkg::OFS_ADDR_EXT, 32'h0000_0000);
    sw.wr(lmac_pkg::OFS_LM_EN, 32'h0000_0001);
    sw.wr(lmac_pkg::OFS_PAGING, 32'h0000_0001);
    rdc(lmac_pkg::OFS_FAULT, 32'h0000_0002);
    rdc(lmac_pkg::OFS_PAGING, 32'h0000_0000);
    sw.wr(lmac_pkg::OFS_ADDR_EXT, 32'h0000_0001);
    sw.wr(lmac_pkg::OFS_CODE, 32'h0000_0001);
    sw.wr(lmac_pkg::OFS_PAGING, 32'h0000_0001);
    rdc(lmac_pkg::OFS_FAULT, 32'h0000_0004);
    rdc(lmac_pkg::OFS_STATUS, 32'h0000_0002);
    chk(32'(fault_cnt), 32'h0000_0005);
    sw.wr(lmac_pkg::OFS_CODE, 32'h0000_0000);
    $display("test entry faults done");
  endtask

  task automatic t_bus;
    logic [31:0] q;
    logic        s;
    sw.rd(8'h1C, q, s);
    chk(q, 32'h0000_0000);
    chk({31'h0000_0000, s}, 32'h0000_0001);
    sw.wr(lmac_pkg::OFS_STATUS, 32'h0000_0007);
    rdc(lmac_pkg::OFS_STATUS, 32'h0000_0002);
    rdc(lmac_pkg::OFS_INT_CLR, 32'h0000_0000);
    $display("test bus done");
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    end_of_test();
  end

  // Main sequence
  initial begin
    arst_n = 1'b0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_enter();
    t_active_faults();
    t_leave();
    t_entry_faults();
    t_bus();
    end_of_test();
  end
endmodule
